// File: rtl/ujb_bridge.sv
// user logic behind the user jtag tile: tuning, debug mux, rom readout, sram init
// Operation
// - tune shift register takes tdi bits on tck only while dr shift flag high
// - dr update copies the tune shift register into the parameter in one step
// - parameter output stays unchanged while shifting is in progress
// - debug mux picks one internal net per user instruction code from 32 up, at most 127
// - selected net drives user serial out, optionally registered on either tck edge
// - optionally several nets go out in turn, one per rising tck edge
// - read-only store addressed as eight pages of 128 bits
// - store page comes serially from host over tdi or from core logic
// - page fetched in parallel without clock, then sent bit by bit
// - readout shifter advances only while dr shift flag high
// - readout loads and shifts by watching capture and shift flags
// - sram init words received serially and written by this logic
// - instruction copy is 8 bits, changing only at ir update
// - shift, update, capture flags high only in their dr states
// - user serial out reaches tdo only while instruction is in user range
// - user test clock and serial input are straight tck and tdi
`default_nettype none
module ujb_bridge
	import ujb_pkg::*;
#(
	parameter int                 PARAM_W    = 16,
	parameter logic [PARAM_W-1:0] PARAM_INIT = '0,
	parameter int                 NUM_NETS   = 8,
	parameter int                 DEBUG_EDGE = ujb_pkg::UJB_EDGE_RISE,
	parameter int                 SRAM_W     = 8,
	parameter int                 SRAM_AW    = 8
) (
	input  wire logic                                 i_clk,
	input  wire logic                                 i_rst,
	input  wire logic                                 i_user_test_clock,
	input  wire logic                                 i_user_serial_in,
	input  wire logic                                 i_dr_shift_flag,
	input  wire logic                                 i_dr_update_flag,
	input  wire logic                                 i_dr_capture_flag,
	input  wire logic [7:0]                           i_instr_reg_copy,
	input  wire logic [NUM_NETS-1:0]                  i_test_nets,
	input  wire logic                                 i_core_page_sel,
	input  wire logic [ujb_pkg::UJB_ROM_AW-1:0]       i_core_page,
	input  wire logic [ujb_pkg::UJB_ROM_PAGE_W-1:0]   i_rom_data,
	output logic      [PARAM_W-1:0]                   o_param,
	output logic                                      o_user_serial_out,
	output logic                                      o_user_range,
	output logic      [ujb_pkg::UJB_ROM_AW-1:0]       o_rom_page,
	output logic                                      o_sram_we,
	output logic      [SRAM_AW-1:0]                   o_sram_addr,
	output logic      [SRAM_W-1:0]                    o_sram_wdata
);
	import ujb_pkg::*;

	localparam int NET_IW = (NUM_NETS > 1) ? $clog2(NUM_NETS) : 1;
	localparam int SBC_W  = $clog2(SRAM_W + 1);

	generate
		if (NUM_NETS < 2 || NUM_NETS > UJB_DBG_MAX || PARAM_W < 1 || SRAM_W < 2 ||
		    SRAM_AW < 1 || DEBUG_EDGE < UJB_EDGE_NONE || DEBUG_EDGE > UJB_EDGE_FALL) begin : g_bad
			$error("ujb_bridge: parameter out of range");
		end
	endgenerate

	// ****************************************************************
	// pin synchroniser
	// ****************************************************************
	// tck is far slower than i_clk, so all tap pins are sampled as plain
	// levels; a clean tck edge is seen as soon as stage two takes it, against the old level in stage three
	logic [UJB_SYNC_W-1:0] sync1_q;
	logic [UJB_SYNC_W-1:0] sync2_q;
	logic                  tck3_q;
	logic                  upd3_q;
	logic                  cap3_q;
	logic [UJB_SYNC_W-1:0] pins;

	assign pins = {i_instr_reg_copy, i_dr_capture_flag, i_dr_update_flag,
	               i_dr_shift_flag, i_user_serial_in, i_user_test_clock};

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sync1_q <= '0;
			sync2_q <= '0;
			tck3_q  <= 1'b0;
			upd3_q  <= 1'b0;
			cap3_q  <= 1'b0;
		end else begin
			sync1_q <= pins;
			sync2_q <= sync1_q;
			tck3_q  <= sync2_q[UJB_B_TCK];
			upd3_q  <= sync2_q[UJB_B_UPDATE];
			cap3_q  <= sync2_q[UJB_B_CAPTURE];
		end
	end

	logic       tck_rise;
	logic       tck_fall;
	logic       upd_rise;
	logic       cap_rise;
	logic       tdi;
	logic       shift_on;
	logic [7:0] instr;
	logic       in_user;
	logic       is_dbg;
	logic [7:0] dbg_off;

	// flags used as tap state markers
	assign tck_rise = sync2_q[UJB_B_TCK] & ~tck3_q;
	assign tck_fall = ~sync2_q[UJB_B_TCK] & tck3_q;
	assign upd_rise = sync2_q[UJB_B_UPDATE] & ~upd3_q;
	assign cap_rise = sync2_q[UJB_B_CAPTURE] & ~cap3_q;
	assign tdi      = sync2_q[UJB_B_TDI];
	assign shift_on = sync2_q[UJB_B_SHIFT] & tck_rise;
	// eight-bit instruction copy, only changed by the tap at ir update
	assign instr    = sync2_q[UJB_B_INSTR +: 8];
	assign in_user  = (instr >= UJB_USER_LO) && (instr <= UJB_USER_HI);
	assign dbg_off  = instr - UJB_I_DBG_BASE;
	assign is_dbg   = (instr >= UJB_I_DBG_BASE) && (dbg_off < 8'(NUM_NETS));

	// ****************************************************************
	// datapath registers
	// ****************************************************************
	logic [PARAM_W-1:0]        tune_sr_q,  tune_sr_d;
	logic [PARAM_W-1:0]        param_q,    param_d;
	logic [UJB_ROM_AW-1:0]     addr_sr_q,  addr_sr_d;
	logic [UJB_ROM_AW-1:0]     host_pg_q,  host_pg_d;
	logic [UJB_ROM_AW-1:0]     page_q,     page_d;
	logic [UJB_ROM_PAGE_W-1:0] rom_sr_q,   rom_sr_d;
	logic [SRAM_W-1:0]         sram_sr_q,  sram_sr_d;
	logic [SBC_W-1:0]          sram_cnt_q, sram_cnt_d;
	logic [SRAM_AW-1:0]        sram_a_q,   sram_a_d;
	logic [SRAM_AW-1:0]        sram_wa_q,  sram_wa_d;
	logic [SRAM_W-1:0]         sram_wd_q,  sram_wd_d;
	logic                      sram_we_q,  sram_we_d;
	logic [NET_IW-1:0]         rr_idx_q,   rr_idx_d;
	logic                      sout_q,     sout_d;
	logic                      range_q,    range_d;
	logic                      dbg_take;

	always_comb begin
		tune_sr_d  = tune_sr_q;
		param_d    = param_q;
		addr_sr_d  = addr_sr_q;
		host_pg_d  = host_pg_q;
		rom_sr_d   = rom_sr_q;
		sram_sr_d  = sram_sr_q;
		sram_cnt_d = sram_cnt_q;
		sram_a_d   = sram_a_q;
		sram_wa_d  = sram_wa_q;
		sram_wd_d  = sram_wd_q;
		sram_we_d  = 1'b0;
		rr_idx_d   = rr_idx_q;
		sout_d     = sout_q;
		dbg_take   = 1'b0;

		if (shift_on && instr == UJB_I_TUNE) begin
			tune_sr_d = {tdi, tune_sr_q[PARAM_W-1:1]};
		end
		// parameter only moves at a tune update
		if (upd_rise && instr == UJB_I_TUNE) begin
			param_d = tune_sr_q;
		end

		if (shift_on && instr == UJB_I_ROM_ADDR) begin
			addr_sr_d = {tdi, addr_sr_q[UJB_ROM_AW-1:1]};
		end
		if (upd_rise && instr == UJB_I_ROM_ADDR) begin
			host_pg_d = addr_sr_q;
		end
		// parallel load at capture, then one bit per shifting tck
		if (instr == UJB_I_ROM_READ) begin
			if (cap_rise) begin
				rom_sr_d = i_rom_data;
			end else if (shift_on) begin
				rom_sr_d = {1'b0, rom_sr_q[UJB_ROM_PAGE_W-1:1]};
			end
		end

		// assemble words and write each one when full
		if (instr == UJB_I_SRAM) begin
			if (cap_rise) begin
				sram_cnt_d = '0;
				sram_a_d   = '0;
			end else if (shift_on) begin
				sram_sr_d = {tdi, sram_sr_q[SRAM_W-1:1]};
				if (sram_cnt_q == SBC_W'(SRAM_W - 1)) begin
					sram_cnt_d = '0;
					sram_we_d  = 1'b1;
					sram_wa_d  = sram_a_q;
					sram_wd_d  = {tdi, sram_sr_q[SRAM_W-1:1]};
					sram_a_d   = sram_a_q + 1'b1;
				end else begin
					sram_cnt_d = sram_cnt_q + 1'b1;
				end
			end
		end

		// choose the edge on which the debug net is sampled
		unique case (DEBUG_EDGE)
			UJB_EDGE_RISE: dbg_take = tck_rise;
			UJB_EDGE_FALL: dbg_take = tck_fall;
			default:       dbg_take = 1'b1;
		endcase

		if (instr == UJB_I_ROM_READ) begin
			sout_d = rom_sr_d[0];
		end else if (instr == UJB_I_TUNE) begin
			sout_d = tune_sr_d[0];
		end else if (is_dbg) begin
			if (dbg_take) begin
				sout_d = i_test_nets[dbg_off[NET_IW-1:0]];
			end
		end else if (instr == UJB_I_DBG_RR) begin
			if (tck_rise) begin
				sout_d   = i_test_nets[rr_idx_q];
				rr_idx_d = (rr_idx_q == NET_IW'(NUM_NETS - 1)) ? '0 : rr_idx_q + 1'b1;
			end
		end else begin
			sout_d = 1'b0;
		end
		if (instr != UJB_I_DBG_RR) begin
			rr_idx_d = '0;
		end
	end

	assign page_d  = i_core_page_sel ? i_core_page : host_pg_q;
	// output qualifies the serial path toward tdo
	assign range_d = in_user;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			tune_sr_q  <= '0;
			// default until the first matching update
			param_q    <= PARAM_INIT;
			addr_sr_q  <= '0;
			host_pg_q  <= '0;
			page_q     <= '0;
			rom_sr_q   <= '0;
			sram_sr_q  <= '0;
			sram_cnt_q <= '0;
			sram_a_q   <= '0;
			sram_wa_q  <= '0;
			sram_wd_q  <= '0;
			sram_we_q  <= 1'b0;
			rr_idx_q   <= '0;
			sout_q     <= 1'b0;
			range_q    <= 1'b0;
		end else begin
			tune_sr_q  <= tune_sr_d;
			param_q    <= param_d;
			addr_sr_q  <= addr_sr_d;
			host_pg_q  <= host_pg_d;
			page_q     <= page_d;
			rom_sr_q   <= rom_sr_d;
			sram_sr_q  <= sram_sr_d;
			sram_cnt_q <= sram_cnt_d;
			sram_a_q   <= sram_a_d;
			sram_wa_q  <= sram_wa_d;
			sram_wd_q  <= sram_wd_d;
			sram_we_q  <= sram_we_d;
			rr_idx_q   <= rr_idx_d;
			sout_q     <= sout_d;
			range_q    <= range_d;
		end
	end

	assign o_param           = param_q;
	assign o_user_serial_out = sout_q;
	assign o_user_range      = range_q;
	assign o_rom_page        = page_q;
	assign o_sram_we         = sram_we_q;
	assign o_sram_addr       = sram_wa_q;
	assign o_sram_wdata      = sram_wd_q;

	// ****************************************************************
	// assertions
	// ****************************************************************
	property p_tune_shift;
		@(posedge i_clk) disable iff (i_rst)
		$changed(tune_sr_q) |-> $past(shift_on && instr == UJB_I_TUNE);
	endproperty
	a_tune_shift: assert property (p_tune_shift) else $error("tune shift without shift flag");
	property p_update_copy;
		@(posedge i_clk) disable iff (i_rst)
		(upd_rise && instr == UJB_I_TUNE) |=> (o_param == $past(tune_sr_q));
	endproperty
	a_update_copy: assert property (p_update_copy) else $error("update did not copy");
	property p_param_stable;
		@(posedge i_clk) disable iff (i_rst)
		$changed(o_param) |-> $past(upd_rise && instr == UJB_I_TUNE);
	endproperty
	a_param_stable: assert property (p_param_stable) else $error("parameter moved");
	property p_param_shift_hold;
		@(posedge i_clk) disable iff (i_rst)
		(sync2_q[UJB_B_SHIFT] && !upd_rise) |=> $stable(o_param);
	endproperty
	a_param_shift_hold: assert property (p_param_shift_hold) else $error("param moved in shift");
	property p_reset_default;
		@(posedge i_clk) i_rst |=> (o_param == PARAM_INIT);
	endproperty
	a_reset_default: assert property (p_reset_default) else $error("param not default");
	property p_rom_load;
		@(posedge i_clk) disable iff (i_rst)
		(cap_rise && instr == UJB_I_ROM_READ) |=> (rom_sr_q == $past(i_rom_data));
	endproperty
	a_rom_load: assert property (p_rom_load) else $error("rom page not loaded");
	property p_rom_static;
		@(posedge i_clk) disable iff (i_rst)
		$changed(rom_sr_q) |-> $past((shift_on || cap_rise) && instr == UJB_I_ROM_READ);
	endproperty
	a_rom_static: assert property (p_rom_static) else $error("rom shifter moved");
	// outside the user range the flag must drop and the serial bit stay quiet
	property p_user_range;
		@(posedge i_clk) disable iff (i_rst)
		1'b1 |=> (o_user_range == $past(in_user)) && (o_user_range || !o_user_serial_out);
	endproperty
	a_user_range: assert property (p_user_range) else $error("user range flag wrong");
	property p_sram_pulse;
		@(posedge i_clk) disable iff (i_rst)
		o_sram_we |=> !o_sram_we;
	endproperty
	a_sram_pulse: assert property (p_sram_pulse) else $error("sram write not one cycle");
	property p_rr_hold;
		@(posedge i_clk) disable iff (i_rst)
		(instr == UJB_I_DBG_RR && !tck_rise) |=> $stable(o_user_serial_out);
	endproperty
	a_rr_hold: assert property (p_rr_hold) else $error("round robin out moved between edges");

	c_tune_update: cover property (@(posedge i_clk) upd_rise && instr == UJB_I_TUNE);
	c_rom_read:    cover property (@(posedge i_clk) shift_on && instr == UJB_I_ROM_READ);
	c_sram_write:  cover property (@(posedge i_clk) o_sram_we);
	c_debug_net:   cover property (@(posedge i_clk) is_dbg && dbg_take);
endmodule
`default_nettype wire

// File: rtl/ujb_pkg.sv
// constants shared by the user-jtag data bridge
`default_nettype none
package ujb_pkg;
	// ****************************************************************
	// instruction codes
	// ****************************************************************
	localparam logic [7:0] UJB_USER_LO    = 8'h10;
	localparam logic [7:0] UJB_USER_HI    = 8'h7F;
	localparam logic [7:0] UJB_I_TUNE     = 8'h10;
	localparam logic [7:0] UJB_I_ROM_ADDR = 8'h11;
	localparam logic [7:0] UJB_I_ROM_READ = 8'h12;
	localparam logic [7:0] UJB_I_SRAM     = 8'h13;
	localparam logic [7:0] UJB_I_DBG_RR   = 8'h14;
	localparam logic [7:0] UJB_I_DBG_BASE = 8'h20;
	localparam int         UJB_DBG_MAX    = 96;

	// ****************************************************************
	// read-only store layout
	// ****************************************************************
	localparam int UJB_ROM_PAGES  = 8;
	localparam int UJB_ROM_PAGE_W = 128;
	localparam int UJB_ROM_AW     = 3;

	// ****************************************************************
	// tap flag sampling and debug register edge choice
	// ****************************************************************
	localparam int UJB_SYNC_W     = 13;
	localparam int UJB_B_TCK      = 0;
	localparam int UJB_B_TDI      = 1;
	localparam int UJB_B_SHIFT    = 2;
	localparam int UJB_B_UPDATE   = 3;
	localparam int UJB_B_CAPTURE  = 4;
	localparam int UJB_B_INSTR    = 5;
	localparam int UJB_EDGE_NONE  = 0;
	localparam int UJB_EDGE_RISE  = 1;
	localparam int UJB_EDGE_FALL  = 2;
endpackage
`default_nettype wire

// File: sim/ujb_host_model.sv
// tap host model driving the user jtag tile pins
`default_nettype none
module ujb_host_model (
	input  wire logic       i_clk,
	input  wire logic       i_tdo,
	output logic            o_tck,
	output logic            o_tdi,
	output logic            o_shift,
	output logic            o_update,
	output logic            o_capture,
	output logic [7:0]      o_instr
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		o_tck = 1'b0;
		o_tdi = 1'b0;
		o_shift = 1'b0;
		o_update = 1'b0;
		o_capture = 1'b0;
		o_instr = 8'h00;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask

	// straight tck pin
	// phases of 4 clocks keep tck well inside the synchroniser limit
	task automatic pulse();
		o_tck = 1'b1;
		tick(4);
		o_tck = 1'b0;
		tick(4);
	endtask

	task automatic set_instr(input logic [7:0] code);
		o_instr = code;
		tick(8);
	endtask

	task automatic scan_dr(input logic [127:0] din, input int n, output logic [127:0] dout);
		dout = '0;
		o_capture = 1'b1;
		pulse();
		o_capture = 1'b0;
		o_shift = 1'b1;
		for (int i = 0; i < n; i++) begin
			o_tdi = din[i];
			tick(4);
			dout[i] = i_tdo;
			pulse();
		end
		o_shift = 1'b0;
		// released data line must not keep looking valid
		o_tdi = ~o_tdi;
		o_update = 1'b1;
		pulse();
		o_update = 1'b0;
		tick(4);
	endtask
endmodule
`default_nettype wire

// File: sim/tb.sv
// self-checking bench for the user jtag data bridge
`default_nettype none
module tb import ujb_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] INIT = 16'hc3a5;
	logic         clk = 1'b0, rst = 1'b1, psel = 1'b0;
	logic [2:0]   page = 3'h0;
	logic [7:0]   nets = 8'h00;
	logic         tck, tdi, shf, upd, cap, uso, urange, we;
	logic [7:0]   instr, saddr, swdata;
	logic [2:0]   rom_page;
	logic [15:0]  o_param;
	logic [15:0]  exp_param = INIT;
	logic [127:0] rom_data;
	logic [127:0] rom [8];
	logic [15:0]  wq [$];
	logic [7:0]   codes [4] = '{8'h0f, 8'h10, 8'h7f, 8'h80};
	int           n_errors = 0, total_checks = 0;

	always #4 clk = ~clk;
	assign rom_data = rom[rom_page];

	ujb_host_model host_u (.i_clk(clk), .i_tdo(uso), .o_tck(tck), .o_tdi(tdi),
		.o_shift(shf), .o_update(upd), .o_capture(cap), .o_instr(instr));

	ujb_bridge #(.PARAM_INIT(INIT)) dut_u (
		.i_clk(clk), .i_rst(rst), .i_user_test_clock(tck), .i_user_serial_in(tdi),
		.i_dr_shift_flag(shf), .i_dr_update_flag(upd), .i_dr_capture_flag(cap),
		.i_instr_reg_copy(instr), .i_test_nets(nets), .i_core_page_sel(psel),
		.i_core_page(page), .i_rom_data(rom_data), .o_param(o_param),
		.o_user_serial_out(uso), .o_user_range(urange), .o_rom_page(rom_page),
		.o_sram_we(we), .o_sram_addr(saddr), .o_sram_wdata(swdata));

	task automatic check(input logic [127:0] got, input logic [127:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// sampled mid-cycle, away from the edge that launches the outputs
	always @(negedge clk) if (we === 1'b1) wq.push_back({saddr, swdata});
	always @(negedge clk) if (shf && !rst) check(128'(o_param), 128'(exp_param));

	// about 5.3k clocks expected; the limit leaves wide margin
	initial begin
		#200_000;
		n_errors++;
		complete_run();
	end

	initial begin
		logic [127:0] d, q;
		logic [2:0]   p;
		void'($urandom(32'h66f1_3cb3));
		for (int i = 0; i < 8; i++) rom[i] = {$urandom, $urandom, $urandom, $urandom};
		host_u.tick(3);
		rst = 1'b0;
		host_u.tick(4);
		check(128'(o_param), 128'(INIT));
		check(128'({uso, urange, rom_page, we}), 128'h0);
		// 20 bits shifted so only the last 16 may land
		for (int r = 0; r < 2; r++) begin
			host_u.set_instr(r ? 8'h15 : UJB_I_TUNE);
			d = 128'($urandom);
			host_u.scan_dr(d, 20, q);
			if (r == 0) exp_param = d[19:4];
			check(128'(o_param), 128'(exp_param));
		end
		$display("test tune done");
		foreach (codes[i]) begin
			host_u.set_instr(codes[i]);
			check(128'(urange), 128'(codes[i] inside {[8'h10:8'h7f]}));
			if (codes[i] != UJB_I_TUNE) check(128'(uso), 128'h0);
		end
		for (int k = 0; k < 8; k++) begin
			nets = 8'($urandom);
			host_u.set_instr(UJB_I_DBG_BASE + 8'(k));
			host_u.pulse();
			check(128'(uso), 128'(nets[k]));
		end
		host_u.set_instr(UJB_I_DBG_RR);
		for (int i = 0; i < 11; i++) begin
			host_u.pulse();
			check(128'(uso), 128'(nets[i % 8]));
		end
		host_u.set_instr(8'h15);
		host_u.set_instr(UJB_I_DBG_RR);
		host_u.pulse();
		check(128'(uso), 128'(nets[0]));
		$display("test debug done");
		// host page first, then core page with a decoy host page
		for (int t = 0; t < 2; t++) begin
			p = 3'($urandom);
			psel = t[0];
			page = t ? p : ~p;
			host_u.set_instr(UJB_I_ROM_ADDR);
			host_u.scan_dr(128'(t ? ~p : p), 3, q);
			check(128'(rom_page), 128'(p));
			host_u.set_instr(UJB_I_ROM_READ);
			host_u.scan_dr(128'h0, 128, q);
			check(q, rom[p]);
			// part read leaves a live bit on the output, which must hold outside shifting
			host_u.scan_dr(128'h0, 5, q);
			check(q, 128'(rom[p][4:0]));
			host_u.pulse();
			host_u.pulse();
			check(128'(uso), 128'(rom[p][5]));
		end
		$display("test rom done");
		// init repeated after reset
		// second pass checks that capture restarts the word address
		for (int s = 0; s < 3; s++) begin
			if (s == 2) begin
				rst = 1'b1;
				host_u.tick(3);
				rst = 1'b0;
				exp_param = INIT;
				host_u.tick(4);
				check(128'(o_param), 128'(INIT));
			end
			host_u.set_instr(UJB_I_SRAM);
			d = {$urandom, $urandom, $urandom, $urandom};
			wq.delete();
			host_u.scan_dr(d, 27, q);
			check(128'(wq.size()), 128'(3));
			foreach (wq[i]) check(128'(wq[i]), 128'({8'(i), d[i*8 +: 8]}));
		end
		$display("test sram done");
		complete_run();
	end
endmodule
`default_nettype wire
